/* rtl/itsm_cfg.svh */
// Function
// - selector code n picks threshold n
// - map a packs inputs 0-7, 3 bits each
// - input 3 selector at 11-9, read-write
// - map b holds inputs 8-11 selectors
// - bits 14-12 pick group level a
// - bits 17-15 pick group level b
// - map a at 2eh, resets to zero
// - map b at 2fh, reserved bits zero
// - thresholds are 10-bit unsigned, lsb lowest
`ifndef ITSM_CFG_SVH
`define ITSM_CFG_SVH

// =====================================================================
// register word indices (byte address is index times four)
`define ITSM_IDX_THR_BASE 6'h29
`define ITSM_IDX_THR_LAST 6'h2c
`define ITSM_IDX_MAP_A 6'h2e
`define ITSM_IDX_MAP_B 6'h2f

// =====================================================================
// field layout
`define ITSM_SEL_W 3
`define ITSM_LVL_W 10
`define ITSM_NUM_LVL 8
`define ITSM_NUM_OWN 12
`define ITSM_NUM_SEL 14
`define ITSM_MAP_A_W 24
`define ITSM_MAP_B_W 18
`define ITSM_MAPB_GA_LSB 12
`define ITSM_MAPB_GB_LSB 15
`define ITSM_THR_HI_LSB 10
`define ITSM_GROUP_FIRST 5'h0c
`define ITSM_GROUP_LAST 5'h11

// =====================================================================
// reset values
`define ITSM_MAP_A_RST 24'h000000
`define ITSM_MAP_B_RST 18'h00000
`define ITSM_THR_RST 10'h000

`endif

/* rtl/itsm_pkg.sv */
`include "itsm_cfg.svh"
package itsm_pkg;

   // =====================================================================
   // bus carriers
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } itsm_avm_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } itsm_avm_rsp_t;

   // =====================================================================
   // evaluation carriers
   typedef struct packed {
      logic valid;
      logic [4:0] index;
      logic [`ITSM_LVL_W-1:0] level;
   } itsm_eval_req_t;

   typedef struct packed {
      logic done;
      logic [4:0] index;
      logic above_a;
      logic above_b;
      logic [`ITSM_LVL_W-1:0] level_a;
      logic [`ITSM_LVL_W-1:0] level_b;
   } itsm_eval_rsp_t;

   typedef logic [`ITSM_NUM_LVL-1:0][`ITSM_LVL_W-1:0] itsm_lvl_bank_t;
   typedef logic [`ITSM_NUM_SEL-1:0][`ITSM_LVL_W-1:0] itsm_sel_bank_t;

   // =====================================================================
   // whole state of the top module
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [`ITSM_MAP_A_W-1:0] map_a;
      logic [`ITSM_MAP_B_W-1:0] map_b;
      itsm_lvl_bank_t thr;
      itsm_sel_bank_t sel;
      itsm_eval_rsp_t ev;
   } itsm_state_t;

endpackage

/* rtl/itsm_level_pick.sv */
`timescale 1ns/1ps
`default_nettype none
`include "itsm_cfg.svh"
module itsm_level_pick (
   input wire itsm_pkg::itsm_lvl_bank_t levels,
   input wire logic [`ITSM_SEL_W-1:0] code,
   output logic [`ITSM_LVL_W-1:0] value
);
   always_comb begin
      value = levels[code];
   end
endmodule
`default_nettype wire

/* rtl/itsm_top.sv */
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "itsm_cfg.svh"
module itsm_top (
   input wire logic mclk,
   input wire logic srst,
   input wire itsm_pkg::itsm_avm_req_t avm_req,
   output itsm_pkg::itsm_avm_rsp_t avm_rsp,
   input wire itsm_pkg::itsm_eval_req_t eval_req,
   output itsm_pkg::itsm_eval_rsp_t eval_rsp,
   output itsm_pkg::itsm_sel_bank_t sel_level
);
   itsm_pkg::itsm_state_t s_reg;
   itsm_pkg::itsm_state_t s_next;
   itsm_pkg::itsm_sel_bank_t pick;
   logic [`ITSM_NUM_SEL-1:0][`ITSM_SEL_W-1:0] codes;
   logic req;
   logic [5:0] widx;
   logic [1:0] thr_k;
   logic [23:0] thr_w;

   // =====================================================================
   // helpers
   function automatic logic [23:0] merge24(
      input logic [23:0] old,
      input logic [31:0] wd,
      input logic [3:0] be
   );
      logic [23:0] r;
      r = old;
      for (int b = 0; b < 3; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] thr_word(
      input itsm_pkg::itsm_lvl_bank_t t,
      input logic [1:0] k
   );
      // reserved 23-20 and upper byte read zero
      return {12'h000, t[{k, 1'b1}], t[{k, 1'b0}]};
   endfunction

   // =====================================================================
   // selector fields
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         codes[i] = s_reg.map_a[i*`ITSM_SEL_W +: `ITSM_SEL_W];
      end
      for (int i = 0; i < 4; i++) begin
         codes[8+i] = s_reg.map_b[i*`ITSM_SEL_W +: `ITSM_SEL_W];
      end
      codes[12] = s_reg.map_b[`ITSM_MAPB_GA_LSB +: `ITSM_SEL_W];
      codes[13] = s_reg.map_b[`ITSM_MAPB_GB_LSB +: `ITSM_SEL_W];
   end

   for (genvar g = 0; g < `ITSM_NUM_SEL; g++) begin : g_pick
      itsm_level_pick u_pick (
         .levels(s_reg.thr),
         .code(codes[g]),
         .value(pick[g])
      );
   end

   // =====================================================================
   // bus and state update
   assign req = avm_req.read | avm_req.write;
   assign widx = avm_req.address[7:2];
   // one wait state: answer in the second request cycle
   assign avm_rsp = '{readdata: s_reg.rdata, waitrequest: req & ~s_reg.ack};
   // merged word so a partial lane write keeps the other level's bits
   assign thr_k = 2'(widx - `ITSM_IDX_THR_BASE);
   assign thr_w = merge24(24'(thr_word(s_reg.thr, thr_k)), avm_req.writedata,
      avm_req.byteenable);
   assign sel_level = s_reg.sel;
   assign eval_rsp = s_reg.ev;

   always_comb begin
      s_next = s_reg;
      s_next.ack = req & ~s_reg.ack;
      s_next.sel = pick;
      // read data latched in the first cycle, stands at the answer
      if (avm_req.read && !s_reg.ack) begin
         if (widx == `ITSM_IDX_MAP_A) begin
            s_next.rdata = {8'h00, s_reg.map_a};
         end else if (widx == `ITSM_IDX_MAP_B) begin
            s_next.rdata = {14'h0000, s_reg.map_b};
         end else if (widx >= `ITSM_IDX_THR_BASE && widx <= `ITSM_IDX_THR_LAST) begin
            s_next.rdata = thr_word(s_reg.thr, 2'(widx - `ITSM_IDX_THR_BASE));
         end else begin
            s_next.rdata = 32'h00000000;
         end
      end
      // writes land only at the edge where waitrequest is low
      if (avm_req.write && s_reg.ack) begin
         if (widx == `ITSM_IDX_MAP_A) begin
            s_next.map_a = merge24(s_reg.map_a, avm_req.writedata, avm_req.byteenable);
         end else if (widx == `ITSM_IDX_MAP_B) begin
            s_next.map_b = 18'(merge24({6'h00, s_reg.map_b}, avm_req.writedata,
               avm_req.byteenable));
         end else if (widx >= `ITSM_IDX_THR_BASE && widx <= `ITSM_IDX_THR_LAST) begin
            s_next.thr[{thr_k, 1'b0}] = thr_w[`ITSM_LVL_W-1:0];
            s_next.thr[{thr_k, 1'b1}] = thr_w[`ITSM_THR_HI_LSB +: `ITSM_LVL_W];
         end
      end
      s_next.ev.done = 1'b0;
      if (eval_req.valid && eval_req.index <= `ITSM_GROUP_LAST) begin
         s_next.ev.done = 1'b1;
         s_next.ev.index = eval_req.index;
         if (eval_req.index < `ITSM_GROUP_FIRST) begin
            s_next.ev.level_a = pick[eval_req.index[3:0]];
            s_next.ev.level_b = `ITSM_THR_RST;
            s_next.ev.above_a = eval_req.level >= pick[eval_req.index[3:0]];
            s_next.ev.above_b = 1'b0;
         end else begin
            s_next.ev.level_a = pick[12];
            s_next.ev.level_b = pick[13];
            s_next.ev.above_a = eval_req.level >= pick[12];
            s_next.ev.above_b = eval_req.level >= pick[13];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // =====================================================================
   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   sequence s_wr_full(logic [5:0] idx);
      avm_req.write && !avm_rsp.waitrequest && widx == idx && avm_req.byteenable == 4'hf;
   endsequence

   sequence s_rd_done(logic [5:0] idx);
      avm_req.read && !avm_rsp.waitrequest && widx == idx;
   endsequence

   a_sel_code_pick: assert property (
      ##1 s_reg.sel[5] == $past(s_reg.thr[s_reg.map_a[17:15]]))
      else $error("selected level does not follow code");

   a_map_a_pack: assert property (
      s_wr_full(`ITSM_IDX_MAP_A) |=> s_reg.map_a[23:21] == $past(avm_req.writedata[23:21])
         && s_reg.map_a[2:0] == $past(avm_req.writedata[2:0]))
      else $error("map a fields not stored in place");

   a_in3_readback: assert property (
      s_rd_done(`ITSM_IDX_MAP_A) |-> avm_rsp.readdata[11:9] == s_reg.map_a[11:9])
      else $error("input 3 selector read back wrong");

   a_map_b_low: assert property (
      s_wr_full(`ITSM_IDX_MAP_B) |=> codes[11] == $past(avm_req.writedata[11:9])
         && codes[8] == $past(avm_req.writedata[2:0]))
      else $error("inputs 8-11 selectors misplaced");

   a_group_a_sel: assert property (
      s_wr_full(`ITSM_IDX_MAP_B) |=> ##1 sel_level[12] == s_reg.thr[$past(
         avm_req.writedata[14:12], 2)])
      else $error("group level a not selected");

   a_group_b_sel: assert property (
      s_wr_full(`ITSM_IDX_MAP_B) |=> ##1 sel_level[13] == s_reg.thr[$past(
         avm_req.writedata[17:15], 2)])
      else $error("group level b not selected");

   a_map_a_reset: assert property (
      $fell(srst) |-> s_reg.map_a == `ITSM_MAP_A_RST)
      else $error("map a not zero after reset");

   a_map_b_resvd: assert property (
      s_rd_done(`ITSM_IDX_MAP_B) |-> avm_rsp.readdata[31:18] == 14'h0000)
      else $error("map b reserved bits not zero");

   a_thr_store: assert property (
      s_wr_full(`ITSM_IDX_THR_BASE) |=> s_reg.thr[1] == $past(avm_req.writedata[19:10])
         && s_reg.thr[0] == $past(avm_req.writedata[9:0]))
      else $error("threshold value not stored lsb first");

   a_eval_live: assert property (
      eval_req.valid && eval_req.index == 5'h03 |=> eval_rsp.done
         && eval_rsp.level_a == $past(s_reg.thr[s_reg.map_a[11:9]])
         && eval_rsp.above_a == ($past(eval_req.level) >= eval_rsp.level_a))
      else $error("evaluation used wrong threshold");

   a_map_b_reset: assert property (
      $fell(srst) |-> s_reg.map_b == `ITSM_MAP_B_RST)
      else $error("map b not zero after reset");

   a_eval_refused: assert property (
      eval_req.valid && eval_req.index > `ITSM_GROUP_LAST |=> !eval_rsp.done)
      else $error("evaluation past the group not ignored");

   a_own_no_group: assert property (
      eval_req.valid && eval_req.index < `ITSM_GROUP_FIRST |=> eval_rsp.done
         && eval_rsp.level_b == `ITSM_THR_RST && !eval_rsp.above_b)
      else $error("own input reported a group b result");

   a_group_eval: assert property (
      eval_req.valid && eval_req.index >= `ITSM_GROUP_FIRST
         && eval_req.index <= `ITSM_GROUP_LAST |=> eval_rsp.done
         && eval_rsp.level_a == $past(s_reg.thr[s_reg.map_b[14:12]])
         && eval_rsp.level_b == $past(s_reg.thr[s_reg.map_b[17:15]]))
      else $error("group input used wrong levels");

endmodule
`default_nettype wire

/* verif/test_input_threshold_select_map.sv */
`timescale 1ns/1ps
`default_nettype none
module test_input_threshold_select_map;
   // =====================================================================
   // clock, reset, dut
   logic mclk;
   logic srst;
   itsm_pkg::itsm_avm_req_t avm_req;
   itsm_pkg::itsm_avm_rsp_t avm_rsp;
   itsm_pkg::itsm_eval_req_t eval_req;
   itsm_pkg::itsm_eval_rsp_t eval_rsp;
   itsm_pkg::itsm_sel_bank_t sel_level;
   int errors;
   int comparisons;
   int cycles = 0;
   logic [31:0] rd;
   logic [3:0] be;
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   itsm_top dut (.mclk(mclk), .srst(srst), .avm_req(avm_req), .avm_rsp(avm_rsp),
      .eval_req(eval_req), .eval_rsp(eval_rsp), .sel_level(sel_level));
   // =====================================================================
   // helpers
   function automatic logic [9:0] lvl(input int n);
      return 10'h005 + 10'(n) * 10'h049;
   endfunction
   function automatic logic [31:0] mapa(input int c);
      logic [31:0] m;
      m = 32'h00000000;
      for (int k = 0; k < 8; k++) m[3*k+:3] = 3'(c + k);
      return m;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // request held until the edge that sees waitrequest low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      avm_req <= '{read: ~wr, write: wr, address: a, writedata: d, byteenable: be};
      do @(posedge mclk); while (avm_rsp.waitrequest !== 1'b0);
      rd = avm_rsp.readdata;
      avm_req.read <= 1'b0;
      avm_req.write <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
      bus(1'b0, a, 32'h00000000);
      chk(rd, exp, msg);
   endtask
   // sel_level lags a register change by one cycle
   task automatic settle();
      @(posedge mclk);
      @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic eval(input logic [4:0] i, input logic [9:0] l, input logic [21:0] exp);
      @(posedge mclk);
      eval_req <= '{valid: 1'b1, index: i, level: l};
      @(posedge mclk);
      eval_req.valid <= 1'b0;
      @(negedge mclk);
      chk({31'h0, eval_rsp.done}, 32'h1, "eval done");
      chk({27'h0, eval_rsp.index}, {27'h0, i}, "eval index");
      chk({10'h0, eval_rsp.above_a, eval_rsp.above_b, eval_rsp.level_b, eval_rsp.level_a},
         {10'h000, exp}, "eval result");
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // =====================================================================
   // hang guard, run needs well under a thousand cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         errors++;
         report_and_stop();
      end
   end
   // =====================================================================
   // tests
   initial begin
      errors = 0;
      comparisons = 0;
      be = 4'hf;
      srst = 1'b1;
      avm_req = '0;
      eval_req = '0;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      rdchk(8'hb8, 32'h00000000, "map a reset");
      rdchk(8'hbc, 32'h00000000, "map b reset");
      rdchk(8'h40, 32'h00000000, "unmapped read");
      $display("test reset done");
      // distinct levels so a wrong pick shows; 10-bit fields lsb lowest
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, 8'(8'ha4 + 8'(4 * k)), {12'h000, lvl(2 * k + 1), lvl(2 * k)});
      end
      rdchk(8'ha8, {12'h000, lvl(3), lvl(2)}, "level word readback");
      // every code lands in every slot of map a across the loop
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, 8'hb8, mapa(c) | 32'hff000000);
         rdchk(8'hb8, mapa(c), "map a readback");
         settle();
         for (int k = 0; k < 8; k++) begin
            chk({22'h0, sel_level[k]}, {22'h0, lvl((c + k) % 8)}, "map a pick");
         end
      end
      bus(1'b1, 8'hb8, 32'h00000a00);
      rdchk(8'hb8, 32'h00000a00, "input 3 field");
      settle();
      chk({22'h0, sel_level[3]}, {22'h0, lvl(5)}, "input 3 pick");
      $display("test map a done");
      bus(1'b1, 8'hbc, 32'hffffffff);
      rdchk(8'hbc, 32'h0003ffff, "map b reserved");
      bus(1'b1, 8'hbc, 32'h0003e8d1);
      rdchk(8'hbc, 32'h0003e8d1, "map b readback");
      settle();
      for (int k = 0; k < 4; k++) begin
         chk({22'h0, sel_level[8 + k]}, {22'h0, lvl(k + 1)}, "map b own pick");
      end
      chk({22'h0, sel_level[12]}, {22'h0, lvl(6)}, "group a pick");
      chk({22'h0, sel_level[13]}, {22'h0, lvl(7)}, "group b pick");
      $display("test map b done");
      // comparisons at equality and one below the chosen level
      eval(5'h0c, lvl(6), {2'b10, lvl(7), lvl(6)});
      eval(5'h0f, lvl(7), {2'b11, lvl(7), lvl(6)});
      eval(5'h03, lvl(5) - 10'h001, {2'b00, 10'h000, lvl(5)});
      // group b cleared to code 0, group a untouched
      bus(1'b1, 8'hbc, 32'h000068d1);
      eval(5'h0c, lvl(6), {2'b11, lvl(0), lvl(6)});
      bus(1'b1, 8'hb8, 32'h00000000);
      eval(5'h03, lvl(0), {2'b10, 10'h000, lvl(0)});
      // index past the group is ignored, no done pulse
      @(posedge mclk);
      eval_req <= '{valid: 1'b1, index: 5'h12, level: 10'h3ff};
      @(posedge mclk);
      eval_req.valid <= 1'b0;
      @(negedge mclk);
      chk({31'h0, eval_rsp.done}, 32'h0, "refused eval");
      $display("test evaluation done");
      // only lane 1 lands, bits 15-8; the other lanes keep their codes
      be = 4'h2;
      bus(1'b1, 8'hbc, 32'hffffffff);
      be = 4'hf;
      rdchk(8'hbc, 32'h0000ffd1, "map b lane write");
      $display("test byte lanes done");
      // mid-run reset clears both maps and the levels
      @(posedge mclk);
      srst <= 1'b1;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      rdchk(8'hb8, 32'h00000000, "map a after reset");
      rdchk(8'hbc, 32'h00000000, "map b after reset");
      rdchk(8'ha4, 32'h00000000, "level word after reset");
      $display("test reset again done");
      report_and_stop();
   end
endmodule
`default_nettype wire
